//--- shared/brd_regs.svh
// constants of the burst rate decoder: sizes, codes and timing counts
`ifndef BRD_REGS_SVH
`define BRD_REGS_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define BRD_CLK_NS 5
`define BRD_ROLL_NS 15
`define BRD_ROLL_CYC ((`BRD_ROLL_NS + `BRD_CLK_NS - 1) / `BRD_CLK_NS)
`define BRD_MEM_DLY_NS 10
`define BRD_MEM_DLY_CYC ((`BRD_MEM_DLY_NS + `BRD_CLK_NS - 1) / `BRD_CLK_NS)
`define BRD_FAST_DLY_NS 10
`define BRD_FAST_DLY_CYC ((`BRD_FAST_DLY_NS + `BRD_CLK_NS - 1) / `BRD_CLK_NS)
`define BRD_P2B_STB_NS 10
`define BRD_P2B_STB_CYC ((`BRD_P2B_STB_NS + `BRD_CLK_NS - 1) / `BRD_CLK_NS)
`define BRD_P2B_RST_NS 5
`define BRD_P2B_RST_CYC ((`BRD_P2B_RST_NS + `BRD_CLK_NS - 1) / `BRD_CLK_NS)

// ----------------------------------------------------------------
// dividers, codes and reset values
// ----------------------------------------------------------------
`define BRD_DIV5_LAST 3'h4
`define BRD_RATE_VOICE 4'h9
`define BRD_FMT_AUTO 3'h0
`define BRD_FMT_LAST 3'h5
`define BRD_FMT_RST 5'h01
`define BRD_ADDR_ONE 10'h001
`define BRD_BANK_ONE 4'h1

`endif

//--- shared/brd_pkg.sv
// types of the burst rate decoder
package brd_pkg;

	typedef struct packed {
		logic [9:0] wr_addr;
		logic wr_msb;
		logic [2:0] wr_roll;
		logic wr_rp;
		logic [9:0] rd_addr;
		logic rd_msb;
		logic [2:0] rd_roll;
		logic rd_rp;
		logic gate;
		logic fast_clk;
		logic [3:0] fast_dly;
		logic fast_stb;
		logic [3:0] wr_dly;
		logic [3:0] rd_dly;
		logic [5:0] wr_word;
		logic wr_pend;
		logic rd_pend;
		logic last_rd;
		logic mem_we;
		logic [9:0] mem_addr;
		logic [5:0] mem_din;
		logic mem_stb;
		logic rd_issue;
		logic lat_stb;
		logic [5:0] out_latch;
		logic data_out;
		logic data_clk;
		logic [2:0] div5;
		logic cnt_tick;
		logic [4:0] div32;
		logic lock_ref;
		logic pdm_prev;
		logic [5:0] pw_cnt;
		logic [5:0] p2b_word;
		logic [2:0] p2b_stb;
		logic [2:0] p2b_rst;
		logic b2p_run;
		logic [5:0] b2p_cnt;
		logic pdm_out;
		logic [4:0] fmt_sel;
	} brd_state_t;

endpackage

//--- src/brd_top.sv
// burst rate decoder: debursting memory, its counters and the voice converters
`include "brd_regs.svh"

// Summary of operation
// - write at burst clock in gate, read continuously
// - interleave reads and writes through one memory
// - voice pulses become 6-bit words and back
// - programmed format wins, else detected format
// - modulus set by rate and format; reload on MSB fall
// - count preset to minus modulus, wrap, rollover pulse
// - mux routes write or read address to memory
// - gate set by one rollover, reset by other
// - gate enables fast clock; delayed copy strobes
// - each clock pulse then delayed memory strobe
// - four banks of 256 six-bit words
// - upper two address bits select one bank
// - read data captured in 6-bit output latch
// - divide by five tick; divide by 32 reference
// - pulse gates ticks into 6-bit counter
// - trailing edge strobes count into register
// - after strobe, brief reset clears counter
// - compare count with word; equality ends pulse
// - b2p_cnt held clear until start pulse
// - exactly one of five format lines asserted
// - several detected: shortest period wins
// - program 1 to 5 bypasses priority chain
// - holds 1000 data bits or 3000 voice bits
module brd_top (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic burst_clk_i,
	input wire logic burst_data_i,
	input wire logic data_clk_i,
	input wire logic fast_tick_i,
	input wire logic pdm_i,
	input wire logic pdm_start_i,
	input wire logic [3:0] rate_prog_i,
	input wire logic [2:0] fmt_prog_i,
	input wire logic [4:0] fmt_det_i,
	output logic [4:0] fmt_sel_o,
	output logic burst_gate_o,
	output logic fast_clk_o,
	output logic fast_strobe_o,
	output logic wr_rollover_o,
	output logic rd_rollover_o,
	output logic mem_strobe_o,
	output logic data_o,
	output logic data_clk_o,
	output logic [5:0] voice_word_o,
	output logic pdm_o,
	output logic lock_ref_o
);

	// ----------------------------------------------------------------
	// preset lookup
	// ----------------------------------------------------------------
	// words per 2 ms burst period, scaled by the format's multiple
	function automatic logic [9:0] brd_preset(input logic [3:0] rate, input logic [4:0] fmt);
		logic [7:0] base;
		logic [9:0] mult;
		logic [9:0] modulus;
		base = 8'h01;
		mult = 10'h001;
		unique case (rate)
			4'h0: base = 8'h01;
			4'h1: base = 8'h03;
			4'h2: base = 8'h06;
			4'h3: base = 8'h0a;
			4'h4: base = 8'h14;
			4'h5: base = 8'h1e;
			4'h6: base = 8'h3c;
			4'h7: base = 8'h64;
			4'h8: base = 8'hc8;
			4'h9: base = 8'h64;
			default: base = 8'h01;
		endcase
		unique case (fmt)
			5'h01: mult = 10'h001;
			5'h02: mult = 10'h002;
			5'h04: mult = 10'h003;
			5'h08: mult = 10'h004;
			5'h10: mult = 10'h005;
			default: mult = 10'h001;
		endcase
		modulus = 10'({2'h0, base} * mult);
		brd_preset = 10'h000 - modulus;
	endfunction

	brd_pkg::brd_state_t s_r;
	brd_pkg::brd_state_t s_nxt;

	// separate from the state struct: an array cannot be packed into it
	logic [5:0] mem_bank [4][256];
	logic [5:0] mem_q;
	logic [3:0] bank_en;

	logic voice;
	logic [9:0] preset;
	logic wr_req;
	logic rd_req;
	logic do_wr;
	logic do_rd;
	logic wr_fall;
	logic rd_fall;
	logic trail;
	logic b2p_end;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		voice = (rate_prog_i == `BRD_RATE_VOICE);
		preset = brd_preset(rate_prog_i, s_r.fmt_sel);

		// format selection
		if (fmt_prog_i != `BRD_FMT_AUTO && fmt_prog_i <= `BRD_FMT_LAST) begin
			s_nxt.fmt_sel = 5'(5'h01 << (fmt_prog_i - 3'h1));
		end else if (fmt_det_i[0]) begin
			s_nxt.fmt_sel = 5'h01;
		end else if (fmt_det_i[1]) begin
			s_nxt.fmt_sel = 5'h02;
		end else if (fmt_det_i[2]) begin
			s_nxt.fmt_sel = 5'h04;
		end else if (fmt_det_i[3]) begin
			s_nxt.fmt_sel = 5'h08;
		end else if (fmt_det_i[4]) begin
			s_nxt.fmt_sel = 5'h10;
		end

		// timing dividers
		s_nxt.cnt_tick = (s_r.div5 == `BRD_DIV5_LAST);
		s_nxt.div5 = s_nxt.cnt_tick ? 3'h0 : s_r.div5 + 3'h1;
		if (s_r.cnt_tick) begin
			s_nxt.div32 = s_r.div32 + 5'h01;
		end
		s_nxt.lock_ref = s_r.div32[4];

		// pulse to binary
		s_nxt.pdm_prev = pdm_i;
		trail = s_r.pdm_prev && !pdm_i;
		if (s_r.p2b_rst != 3'h0) begin
			s_nxt.p2b_rst = s_r.p2b_rst - 3'h1;
			s_nxt.pw_cnt = 6'h00;
		end else if (pdm_i && s_r.cnt_tick) begin
			s_nxt.pw_cnt = s_r.pw_cnt + 6'h01;
		end
		if (trail) begin
			s_nxt.p2b_word = s_r.pw_cnt;
			s_nxt.p2b_stb = 3'(`BRD_P2B_STB_CYC);
		end else if (s_r.p2b_stb != 3'h0) begin
			s_nxt.p2b_stb = s_r.p2b_stb - 3'h1;
			if (s_r.p2b_stb == 3'h1) begin
				s_nxt.p2b_rst = 3'(`BRD_P2B_RST_CYC);
			end
		end

		// binary to pulse
		b2p_end = 1'b0;
		if (!s_r.b2p_run) begin
			s_nxt.b2p_cnt = 6'h00;
			if (pdm_start_i) begin
				s_nxt.b2p_run = 1'b1;
				s_nxt.pdm_out = 1'b1;
			end
		end else if (s_r.cnt_tick) begin
			if (s_r.b2p_cnt == s_r.out_latch) begin
				s_nxt.b2p_run = 1'b0;
				s_nxt.pdm_out = 1'b0;
				s_nxt.b2p_cnt = 6'h00;
				b2p_end = 1'b1;
			end else begin
				s_nxt.b2p_cnt = s_r.b2p_cnt + 6'h01;
			end
		end

		// write and read requests, then the delayed memory strobe
		wr_req = s_r.gate && (voice ? trail : burst_clk_i);
		rd_req = voice ? b2p_end : data_clk_i;
		if (wr_req) begin
			s_nxt.wr_word = voice ? s_r.pw_cnt : {5'h00, burst_data_i};
		end
		s_nxt.wr_dly = {s_r.wr_dly[2:0], wr_req};
		s_nxt.rd_dly = {s_r.rd_dly[2:0], rd_req};

		// arbitration: alternate when both wait
		do_wr = s_r.wr_pend && (!s_r.rd_pend || s_r.last_rd);
		do_rd = s_r.rd_pend && !do_wr;
		s_nxt.wr_pend = (s_r.wr_pend && !do_wr) || s_r.wr_dly[`BRD_MEM_DLY_CYC - 1];
		s_nxt.rd_pend = (s_r.rd_pend && !do_rd) || s_r.rd_dly[`BRD_MEM_DLY_CYC - 1];
		if (do_wr || do_rd) begin
			s_nxt.last_rd = do_rd;
		end
		s_nxt.mem_we = do_wr;
		s_nxt.rd_issue = do_rd;
		s_nxt.mem_stb = do_wr || do_rd;
		s_nxt.mem_addr = do_wr ? s_r.wr_addr : s_r.rd_addr;
		s_nxt.mem_din = s_r.wr_word;

		// output latch
		s_nxt.lat_stb = s_r.rd_issue;
		s_nxt.data_clk = 1'b0;
		if (s_r.lat_stb) begin
			s_nxt.out_latch = mem_q;
			s_nxt.data_out = mem_q[0];
			s_nxt.data_clk = !voice;
		end

		// address counters
		s_nxt.wr_msb = s_r.wr_addr[9];
		s_nxt.rd_msb = s_r.rd_addr[9];
		wr_fall = s_r.wr_msb && !s_r.wr_addr[9];
		rd_fall = s_r.rd_msb && !s_r.rd_addr[9];
		if (wr_fall) begin
			s_nxt.wr_addr = preset;
			s_nxt.wr_msb = preset[9];
			s_nxt.wr_roll = 3'(`BRD_ROLL_CYC);
		end else begin
			if (do_wr) begin
				s_nxt.wr_addr = s_r.wr_addr + `BRD_ADDR_ONE;
			end
			if (s_r.wr_roll != 3'h0) begin
				s_nxt.wr_roll = s_r.wr_roll - 3'h1;
			end
		end
		if (rd_fall) begin
			s_nxt.rd_addr = preset;
			s_nxt.rd_msb = preset[9];
			s_nxt.rd_roll = 3'(`BRD_ROLL_CYC);
		end else begin
			if (do_rd) begin
				s_nxt.rd_addr = s_r.rd_addr + `BRD_ADDR_ONE;
			end
			if (s_r.rd_roll != 3'h0) begin
				s_nxt.rd_roll = s_r.rd_roll - 3'h1;
			end
		end
		s_nxt.wr_rp = (s_nxt.wr_roll != 3'h0);
		s_nxt.rd_rp = (s_nxt.rd_roll != 3'h0);

		// burst gate: set wins when both rollovers coincide
		if (rd_fall) begin
			s_nxt.gate = 1'b1;
		end else if (wr_fall) begin
			s_nxt.gate = 1'b0;
		end
		s_nxt.fast_clk = s_r.gate && fast_tick_i;
		s_nxt.fast_dly = {s_r.fast_dly[2:0], s_r.fast_clk};
		s_nxt.fast_stb = s_r.fast_dly[`BRD_FAST_DLY_CYC - 1];
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			s_r <= '0;
			// msb high makes both counters load their preset at once
			s_r.wr_msb <= 1'b1;
			s_r.rd_msb <= 1'b1;
			s_r.fmt_sel <= `BRD_FMT_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// buffer memory
	// ----------------------------------------------------------------
	assign bank_en = 4'(`BRD_BANK_ONE << s_r.mem_addr[9:8]);

	always_ff @(posedge clk_sys_i) begin
		for (int b = 0; b < 4; b++) begin
			if (s_r.mem_we && bank_en[b]) begin
				mem_bank[b][s_r.mem_addr[7:0]] <= s_r.mem_din;
			end
		end
		mem_q <= mem_bank[s_r.mem_addr[9:8]][s_r.mem_addr[7:0]];
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign fmt_sel_o = s_r.fmt_sel;
	assign burst_gate_o = s_r.gate;
	assign fast_clk_o = s_r.fast_clk;
	assign fast_strobe_o = s_r.fast_stb;
	assign wr_rollover_o = s_r.wr_rp;
	assign rd_rollover_o = s_r.rd_rp;
	assign mem_strobe_o = s_r.mem_stb;
	assign data_o = s_r.data_out;
	assign data_clk_o = s_r.data_clk;
	assign voice_word_o = s_r.p2b_word;
	assign pdm_o = s_r.pdm_out;
	assign lock_ref_o = s_r.lock_ref;

endmodule

//--- bench/brd_properties.sv
// port assertions and covers for the burst rate decoder
module brd_chk (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic burst_clk_i,
	input wire logic burst_data_i,
	input wire logic data_clk_i,
	input wire logic fast_tick_i,
	input wire logic pdm_i,
	input wire logic pdm_start_i,
	input wire logic [3:0] rate_prog_i,
	input wire logic [2:0] fmt_prog_i,
	input wire logic [4:0] fmt_det_i,
	input wire logic [4:0] fmt_sel_o,
	input wire logic burst_gate_o,
	input wire logic fast_clk_o,
	input wire logic fast_strobe_o,
	input wire logic wr_rollover_o,
	input wire logic rd_rollover_o,
	input wire logic mem_strobe_o,
	input wire logic data_o,
	input wire logic data_clk_o,
	input wire logic [5:0] voice_word_o,
	input wire logic pdm_o,
	input wire logic lock_ref_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	// cycles since reset: a deep $past would otherwise reach pre-reset unknowns
	logic [1:0] since_rst_r;
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			since_rst_r <= 2'h0;
		end else if (since_rst_r != 2'h3) begin
			since_rst_r <= since_rst_r + 2'h1;
		end
	end
	// ----------------------------------------
	// format selection
	// ----------------------------------------
	fmt_onehot_a: assert property ($onehot(fmt_sel_o))
		else $error("format select not one-hot");
	fmt_prog_a: assert property (fmt_prog_i inside {[1:5]}
		|=> fmt_sel_o == (5'h01 << ($past(fmt_prog_i) - 3'h1))) else $error("program ignored");
	fmt_prio_a: assert property (!(fmt_prog_i inside {[1:5]}) && fmt_det_i != 5'h00
		|=> fmt_sel_o == ($past(fmt_det_i) & -$past(fmt_det_i))) else $error("bad priority");
	// ----------------------------------------
	// gate, fast clock and rollovers
	// ----------------------------------------
	fast_gate_a: assert property (fast_clk_o == $past(burst_gate_o && fast_tick_i))
		else $error("fast clock not gated");
	fast_stb_a: assert property (since_rst_r[1] |-> fast_strobe_o == $past(fast_clk_o, 3))
		else $error("fast strobe delay wrong");
	wr_roll_a: assert property ($rose(wr_rollover_o)
		|-> wr_rollover_o[*3] ##1 !wr_rollover_o) else $error("write rollover width");
	rd_roll_a: assert property ($rose(rd_rollover_o)
		|-> rd_rollover_o[*3] ##1 !rd_rollover_o) else $error("read rollover width");
	gate_set_a: assert property ($rose(rd_rollover_o) |-> ##[0:2] burst_gate_o)
		else $error("gate not set");
	gate_clr_a: assert property ($rose(wr_rollover_o) && !rd_rollover_o
		|-> ##[0:2] !burst_gate_o) else $error("gate not cleared");
	// ----------------------------------------
	// memory and voice paths, lock reference
	// ----------------------------------------
	dclk_src_a: assert property (data_clk_o |-> $past(mem_strobe_o, 2))
		else $error("data clock without access");
	b2p_start_a: assert property (pdm_start_i && !pdm_o |=> pdm_o)
		else $error("start did not open pulse");
	lock_ref_a: assert property ($rose(lock_ref_o) |-> ##80 $fell(lock_ref_o))
		else $error("lock reference half period");
	cover property ($rose(burst_gate_o));
	cover property (data_clk_o);
	cover property ($fell(pdm_o));
endmodule

bind brd_top brd_chk chk (.*);

//--- bench/brd_rx_model.sv
// receiver model handing regenerated bursted bits and their clock ticks
module brd_rx_model (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [2:0] bits_i,
	input wire logic [3:0] gap_i,
	output logic burst_clk_o,
	output logic burst_data_o,
	output logic busy_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		burst_clk_o = 1'b0;
		burst_data_o = 1'b0;
		busy_o = 1'b0;
		forever begin
			@(posedge clk_i);
			if (go_i === 1'b1) begin
				busy_o = 1'b1;
				#1;
				for (int k = 0; k < 3; k++) begin
					burst_clk_o = 1'b1;
					burst_data_o = bits_i[k];
					@(posedge clk_i);
					#1;
					burst_clk_o = 1'b0;
					// no pull on the line: stale bit must not look valid
					burst_data_o = ~bits_i[k];
					repeat (gap_i) @(posedge clk_i);
					#1;
				end
				busy_o = 1'b0;
			end
		end
	end
endmodule

//--- bench/burst_rate_decoder_test.sv
// self-checking bench of the burst rate decoder
module burst_rate_decoder_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys_i, rst_i = 1'b1, data_clk_i = 1'b0, fast_tick_i = 1'b0;
	logic pdm_i = 1'b0, pdm_start_i = 1'b0, go = 1'b0, busy;
	logic burst_clk_i, burst_data_i, burst_gate_o, fast_clk_o, fast_strobe_o;
	logic wr_rollover_o, rd_rollover_o, mem_strobe_o, data_o, data_clk_o, pdm_o, lock_ref_o;
	logic [3:0] rate_prog_i = 4'h1, gap = 4'h4;
	logic [2:0] fmt_prog_i = 3'h1, bits = 3'h0;
	logic [4:0] fmt_det_i = 5'h00, fmt_sel_o;
	logic [5:0] voice_word_o;
	logic [2:0] pat [2] = '{3'h5, 3'h2};
	logic [2:0] fp [9] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h0, 3'h0, 3'h7};
	logic [4:0] fd [9] = '{5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h18, 5'h1f, 5'h00, 5'h06};
	logic [4:0] fe [9] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h08, 5'h01, 5'h01, 5'h02};
	int failures = 0, n_compared = 0;
	brd_top dut (.*);
	brd_rx_model rx (.clk_i(clk_sys_i), .go_i(go), .bits_i(bits), .gap_i(gap),
		.burst_clk_o(burst_clk_i), .burst_data_o(burst_data_i), .busy_o(busy));
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	initial forever begin
		@(posedge clk_sys_i);
		#1;
		fast_tick_i = ~fast_tick_i;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task results;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wait_sig(input int which, input logic lvl);
		logic s;
		for (int i = 0; i < 400; i++) begin
			@(posedge clk_sys_i);
			#1;
			s = which == 0 ? data_clk_o : which == 1 ? burst_gate_o : which == 2 ? pdm_o : busy;
			if (s === lvl)
				return;
		end
		failures++;
		$display("ERROR wait %0d expected %b seen timeout", which, lvl);
		results();
	endtask
	// one-cycle pulse on go (0), data_clk_i (1) or pdm_start_i (2)
	task automatic tick(input int which);
		for (int v = 1; v >= 0; v--) begin
			@(posedge clk_sys_i);
			#1;
			if (which == 0)
				go = 1'(v);
			else if (which == 1)
				data_clk_i = 1'(v);
			else
				pdm_start_i = 1'(v);
		end
	endtask
	task automatic send(input logic [2:0] b, input logic [3:0] g);
		bits = b;
		gap = g;
		tick(0);
		wait_sig(3, 1'b0);
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		@(posedge clk_sys_i);
		#1;
		check("fmt_rst", 8'(fmt_sel_o), 8'h01);
		check("gate_rst", 8'(burst_gate_o), 8'h00);
		@(posedge clk_sys_i);
		#1;
		rst_i = 1'b0;
		wait_sig(1, 1'b1);
		$display("test reset done");
		for (int r = 0; r < 2; r++) begin
			send(pat[r], r == 0 ? 4'h4 : 4'hc);
			wait_sig(1, 1'b0);
			// gate closed: these bits must never reach memory
			send(~pat[r], 4'h4);
			for (int k = 0; k < 3; k++) begin
				tick(1);
				wait_sig(0, 1'b1);
				check("data", 8'(data_o), 8'(pat[r][k]));
			end
			wait_sig(1, 1'b1);
		end
		$display("test burst data done");
		for (int i = 0; i < 9; i++) begin
			@(posedge clk_sys_i);
			#1;
			fmt_prog_i = fp[i];
			fmt_det_i = fd[i];
			repeat (2) @(posedge clk_sys_i);
			#1;
			check("fmt_sel", 8'(fmt_sel_o), 8'(fe[i]));
		end
		$display("test format done");
		rate_prog_i = 4'h9;
		foreach (fe[i]) begin
			if (i < 3) begin
				pdm_i = 1'b1;
				repeat (5 * (i == 0 ? 1 : i == 1 ? 12 : 63)) @(posedge clk_sys_i);
				#1;
				pdm_i = 1'b0;
				repeat (2) @(posedge clk_sys_i);
				#1;
				check("voice", 8'(voice_word_o), i == 0 ? 8'h01 : i == 1 ? 8'h0c : 8'h3f);
				repeat (8) @(posedge clk_sys_i);
				#1;
			end
		end
		$display("test voice words done");
		tick(2);
		check("pdm_start", 8'(pdm_o), 8'h01);
		wait_sig(2, 1'b0);
		$display("test voice pulse done");
		results();
	end
endmodule
